//--- rtl/tccu_pkg.sv
// Shared constants and types for the timer capture and compare unit.
// Assumes a single 20 MHz clock and synchronous inputs.
package tccu_pkg;

    // Number of independent units
    localparam int UNITS = 2;

    // Register map, byte offsets, one register per offset
    localparam logic [3:0] OFS_CTRL0  = 4'h0;  // unit 0 control
    localparam logic [3:0] OFS_SRC0   = 4'h1;  // unit 0 source select
    localparam logic [3:0] OFS_HOLDL0 = 4'h2;  // unit 0 holding low byte
    localparam logic [3:0] OFS_HOLDH0 = 4'h3;  // unit 0 holding high byte
    localparam logic [3:0] OFS_CTRL1  = 4'h4;  // unit 1 control
    localparam logic [3:0] OFS_SRC1   = 4'h5;  // unit 1 source select
    localparam logic [3:0] OFS_HOLDL1 = 4'h6;  // unit 1 holding low byte
    localparam logic [3:0] OFS_HOLDH1 = 4'h7;  // unit 1 holding high byte
    localparam logic [3:0] OFS_FLAGS  = 4'h8;  // event flags, write one to clear
    localparam logic [3:0] OFS_ENAB   = 4'h9;  // event enables
    localparam logic [3:0] OFS_STEP   = 4'h4;  // offset step between units

    // Control field positions
    localparam int CTRL_EN_BIT  = 7;
    localparam int CTRL_OUT_BIT = 5;

    // Reset values
    localparam logic [7:0]  CTRL_RST = 8'h00;
    localparam logic [15:0] HOLD_RST = 16'h0000;
    localparam logic [3:0]  PRE_RST  = 4'h0;

    // Mode field encoding
    // local mode field encoding
    typedef enum logic [3:0] {
        MODE_OFF      = 4'b0000,
        MODE_CMP_TGL  = 4'b0010,
        MODE_CMP_SET  = 4'b1000,
        MODE_CMP_CLR  = 4'b1001,
        MODE_CMP_SWI  = 4'b1010,
        MODE_CMP_TRIG = 4'b1011,
        MODE_CAP_FALL = 4'b0100,
        MODE_CAP_RISE = 4'b0101,
        MODE_CAP_R4   = 4'b0110,
        MODE_CAP_R16  = 4'b0111
    } tccu_mode_t;

    // Prescale terminal counts
    localparam logic [3:0] PRE_TC4  = 4'h3;
    localparam logic [3:0] PRE_TC16 = 4'hF;

    // Capture sources, three-bit select
    localparam logic [2:0] SRC_PIN = 3'h0;

    // Per-unit state
    typedef struct packed {
        logic [7:0]  ctrl;     // enable, output, mode
        logic [2:0]  src;      // capture source select
        logic [15:0] hold;     // holding pair
        logic [3:0]  pre;      // capture prescaler
        logic        sync1;    // synchroniser stage one
        logic        sync2;    // synchroniser stage two
        logic        prev;     // previous synced level
        logic        outl;     // compare output latch
        logic        flag;     // event flag
        logic        ien;      // event enable
        logic        hit;      // last cycle matched
        logic        trig;     // conversion trigger pulse
    } tccu_unit_t;

    // Whole block state
    typedef struct packed {
        tccu_unit_t [UNITS-1:0] u;
        logic [7:0]             rdata;
    } tccu_state_t;

    // Register port bundle
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tccu_bus_t;

    // Capture inputs per unit
    typedef struct packed {
        logic pin;
        logic cmp1;
        logic cmp2;
        logic ioc;
        logic [3:0] lc;
    } tccu_src_t;

endpackage : tccu_pkg

//--- rtl/tccu_top.sv
// Two capture and compare units on a shared 16-bit timer, with a byte register port.
// Assumes the timer and the sleep control sit outside; inputs are synchronous to clk.
// Functional notes
// - Two identical units, independent registers
// - Capture copies full timer into holding
// - Mode picks falling, rising, 4th, 16th
// - Capture sets flag; only software clears
// - New capture overwrites old value silently
// - Source select picks one of eight
// - Pin level observed even when output
// - Mode change may give false interrupt
// - Prescaler cleared when off or not capture
// - Prescale switch keeps counter; clear first
// - Timer holds count during sleep
// - Capture works in sleep with external clock
// - Compare match toggles, sets, clears, triggers
// - Every match sets flag with action
// - Clearing control forces output latch low
// - Output also offered to other peripherals
// - Match with trigger selected starts conversion
// - Timer reset needs match still holding
// - Enabled compare interrupt wakes device
`timescale 1ns/1ps
`default_nettype none

module tccu_top
    import tccu_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire tccu_pkg::tccu_bus_t bus,
    output logic [7:0]             rdata,
    input  wire logic [15:0]       timer_count,
    input  wire logic              timer_ext_clk,
    input  wire logic              sleep,
    input  wire tccu_pkg::tccu_src_t [1:0] src_in,
    input  wire logic [1:0]        trig_select,
    output logic [1:0]             unit_out,
    output logic [1:0]             unit_out_int,
    output logic [1:0]             conv_trig,
    output logic [1:0]             timer_reset,
    output logic [1:0]             event_flag,
    output logic                   wake
);
    import tccu_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    tccu_state_t st_r;   // Registered state
    tccu_state_t st_nxt; // Next state

    // Timer advances only while awake or externally clocked
    // frozen timer keeps its count in sleep
    logic timer_live;
    assign timer_live = !sleep || timer_ext_clk;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        logic [7:0] rd;
        tccu_mode_t md;
        logic cap;
        logic cmp;
        logic lvl;
        logic edge_ev;
        logic ev;
        logic match;
        logic [3:0] base;
        rd = 8'h00;
        md = MODE_OFF;
        cap = 1'b0;
        cmp = 1'b0;
        lvl = 1'b0;
        edge_ev = 1'b0;
        ev = 1'b0;
        match = 1'b0;
        base = 4'h0;
        st_nxt = st_r;
        for (int i = 0; i < UNITS; i++)
        begin
            base = 4'(i) * OFS_STEP;
            md = tccu_mode_t'(st_r.u[i].ctrl[3:0]);
            cap = st_r.u[i].ctrl[CTRL_EN_BIT] && (st_r.u[i].ctrl[3:2] == 2'b01);
            cmp = st_r.u[i].ctrl[CTRL_EN_BIT] && (md == MODE_CMP_TGL || st_r.u[i].ctrl[3]);
            // source mux, pin level taken directly
            case (st_r.u[i].src)
                3'h0: lvl = src_in[i].pin;
                3'h1: lvl = src_in[i].cmp1;
                3'h2: lvl = src_in[i].cmp2;
                3'h3: lvl = src_in[i].ioc;
                3'h4: lvl = src_in[i].lc[0];
                3'h5: lvl = src_in[i].lc[1];
                3'h6: lvl = src_in[i].lc[2];
                default: lvl = src_in[i].lc[3];
            endcase
            st_nxt.u[i].sync1 = lvl;
            st_nxt.u[i].sync2 = st_r.u[i].sync1;
            st_nxt.u[i].prev = st_r.u[i].sync2;
            edge_ev = (md == MODE_CAP_FALL) ? (st_r.u[i].prev && !st_r.u[i].sync2)
                                            : (!st_r.u[i].prev && st_r.u[i].sync2);
            ev = 1'b0;
            // event qualification; capture runs only while timer is live
            if (cap && edge_ev && timer_live)
            begin
                if (md == MODE_CAP_R4)
                begin
                    ev = (st_r.u[i].pre == PRE_TC4);
                    st_nxt.u[i].pre = ev ? PRE_RST : st_r.u[i].pre + 4'h1;
                end
                else if (md == MODE_CAP_R16)
                begin
                    ev = (st_r.u[i].pre == PRE_TC16);
                    st_nxt.u[i].pre = st_r.u[i].pre + 4'h1;
                end
                else
                begin
                    ev = 1'b1;
                end
            end
            // prescaler cleared when off or not capturing
            // direct prescale switch keeps the count
            if (!cap)
            begin
                st_nxt.u[i].pre = PRE_RST;
            end
            if (ev)
            begin
                st_nxt.u[i].hold = timer_count;
            end
            // compare; no match while timer frozen
            match = cmp && timer_live && (st_r.u[i].hold == timer_count);
            st_nxt.u[i].hit = match;
            st_nxt.u[i].trig = 1'b0;
            if (match && !st_r.u[i].hit)
            begin
                case (md)
                    MODE_CMP_TGL: st_nxt.u[i].outl = !st_r.u[i].outl;
                    MODE_CMP_SET: st_nxt.u[i].outl = 1'b1;
                    MODE_CMP_CLR: st_nxt.u[i].outl = 1'b0;
                    default:      st_nxt.u[i].outl = st_r.u[i].outl;
                endcase
                st_nxt.u[i].trig = trig_select[i];
            end
            // Register writes
            if (bus.wr)
            begin
                if (bus.addr == base + OFS_CTRL0)
                begin
                    st_nxt.u[i].ctrl = {bus.wdata[7], 1'b0, 1'b0, bus.wdata[4:0]};
                    if (bus.wdata == CTRL_RST)
                    begin
                        st_nxt.u[i].outl = 1'b0;
                    end
                end
                else if (bus.addr == base + OFS_SRC0)
                begin
                    st_nxt.u[i].src = bus.wdata[2:0];
                end
                else if (bus.addr == base + OFS_HOLDL0 && !ev)
                begin
                    st_nxt.u[i].hold[7:0] = bus.wdata;
                end
                else if (bus.addr == base + OFS_HOLDH0 && !ev)
                begin
                    st_nxt.u[i].hold[15:8] = bus.wdata;
                end
                else if (bus.addr == OFS_FLAGS && bus.wdata[i])
                begin
                    st_nxt.u[i].flag = 1'b0;
                end
                else if (bus.addr == OFS_ENAB)
                begin
                    st_nxt.u[i].ien = bus.wdata[i];
                end
            end
            // capture event or first match cycle sets flag, winning over a same-cycle clear
            if (ev || (match && !st_r.u[i].hit))
            begin
                st_nxt.u[i].flag = 1'b1;
            end
        end
        // Read mux, data in the next cycle
        if (bus.rd)
        begin
            for (int i = 0; i < UNITS; i++)
            begin
                base = 4'(i) * OFS_STEP;
                if (bus.addr == base + OFS_CTRL0)
                begin
                    rd = {st_r.u[i].ctrl[7], 1'b0, st_r.u[i].outl, st_r.u[i].ctrl[4:0]};
                end
                else if (bus.addr == base + OFS_SRC0)
                begin
                    rd = {5'h00, st_r.u[i].src};
                end
                else if (bus.addr == base + OFS_HOLDL0)
                begin
                    rd = st_r.u[i].hold[7:0];
                end
                else if (bus.addr == base + OFS_HOLDH0)
                begin
                    rd = st_r.u[i].hold[15:8];
                end
            end
            if (bus.addr == OFS_FLAGS)
            begin
                rd = {6'h00, st_r.u[1].flag, st_r.u[0].flag};
            end
            else if (bus.addr == OFS_ENAB)
            begin
                rd = {6'h00, st_r.u[1].ien, st_r.u[0].ien};
            end
        end
        st_nxt.rdata = rd;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata = st_r.rdata;
    assign wake = (st_r.u[0].flag && st_r.u[0].ien) || (st_r.u[1].flag && st_r.u[1].ien);
    for (genvar g = 0; g < UNITS; g++)
    begin : g_out
        assign unit_out[g]     = st_r.u[g].outl;
        assign unit_out_int[g] = st_r.u[g].outl;
        assign conv_trig[g]    = st_r.u[g].trig;
        assign event_flag[g]   = st_r.u[g].flag;
        // reset only if match still holds
        assign timer_reset[g]  = st_r.u[g].trig && st_r.u[g].hit && (st_r.u[g].hold == timer_count);

        flag_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
            $fell(st_r.u[g].flag) |-> $past(bus.wr) && $past(bus.addr) == OFS_FLAGS)
            else $error("flag cleared without software");
        pre_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
            !$past(st_r.u[g].ctrl[CTRL_EN_BIT]) |-> st_r.u[g].pre == PRE_RST)
            else $error("prescaler not cleared");
        out_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
            $past(bus.wr) && $past(bus.addr) == 4'(g) * OFS_STEP && $past(bus.wdata) == CTRL_RST
            |-> !st_r.u[g].outl)
            else $error("output latch not cleared");
        trig_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
            st_r.u[g].trig |-> st_r.u[g].flag)
            else $error("trigger without flag");
        reset_match_a: assert property (@(posedge clk) disable iff (!rst_b)
            timer_reset[g] |-> st_r.u[g].hold == timer_count)
            else $error("timer reset without match");
        cap_value_a: assert property (@(posedge clk) disable iff (!rst_b)
            $changed(st_r.u[g].hold) && !$past(bus.wr) |-> st_r.u[g].hold == $past(timer_count))
            else $error("capture value wrong");
        cmp_set_a: assert property (@(posedge clk) disable iff (!rst_b)
            $rose(st_r.u[g].hit) && $past(st_r.u[g].ctrl[3:0]) == MODE_CMP_SET
            && !$past(bus.wr) |-> st_r.u[g].outl)
            else $error("set mode did not set");
        pre_bound_a: assert property (@(posedge clk) disable iff (!rst_b)
            st_r.u[g].ctrl[3:0] == MODE_CAP_R4 && st_r.u[g].ctrl[7] |=> st_r.u[g].pre <= PRE_TC4)
            else $error("prescale beyond four");
    end

endmodule : tccu_top

`default_nettype wire

//--- tb/tccu_timer_model.sv
// Behavioural shared 16-bit timer that drives the unit's timer count.
// Assumes the bench loads it and starts or stops it between edges.
`timescale 1ns/1ps
`default_nettype none

module tccu_timer_model
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        run,
    input  wire logic        load,
    input  wire logic [15:0] load_val,
    output logic [15:0]      count
);
    // ------------------------------------------
    // Timer counter
    // ------------------------------------------
    // synchronous timer mode, instruction clock
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            count <= 16'h0000;
        else if (load)
            count <= load_val;
        else if (run)
            count <= count + 16'h0001;
    end
endmodule : tccu_timer_model
`default_nettype wire

//--- tb/tccu_top_test.sv
// Self-checking bench for the two-unit capture and compare block.
// Assumes the timer model of tccu_timer_model stands in for the shared timer.
`timescale 1ns/1ps
`default_nettype none

module tccu_top_test;
    import tccu_pkg::*;

    logic clk = 1'b0, rst_b = 1'b0, run = 1'b0, load = 1'b0;
    logic [15:0] load_val = 16'h0000, tcnt;
    logic ext = 1'b0, slp = 1'b0;
    logic [1:0] tsel = 2'b00;
    tccu_bus_t bus = '0;
    tccu_src_t [1:0] src = '0;
    logic [7:0] rdata;
    logic [1:0] uo, uoi, ctrg, trst, flg;
    logic wake;
    int error_cnt = 0, n_compared = 0;

    always #25 clk = ~clk;

    tccu_top i_tccu_top (.clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata), .timer_count(tcnt),
        .timer_ext_clk(ext), .sleep(slp), .src_in(src), .trig_select(tsel), .unit_out(uo),
        .unit_out_int(uoi), .conv_trig(ctrg), .timer_reset(trst), .event_flag(flg), .wake(wake));
    tccu_timer_model i_tccu_timer_model (.clk(clk), .rst_b(rst_b), .run(run), .load(load),
        .load_val(load_val), .count(tcnt));

    // Compare and report
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus.addr <= a; bus.wdata <= d; bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
        @(posedge clk);
        bus.addr <= a; bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk(nm, rdata, e);
    endtask : rd

    // Load timer, then run or hold
    task automatic tmr(input logic [15:0] v, input logic r);
        @(posedge clk);
        load <= 1'b1; load_val <= v; run <= 1'b0;
        @(posedge clk);
        load <= 1'b0; run <= r;
    endtask : tmr

    // Drive source line of unit u: sel 0 pin, 1 comparator one
    task automatic lvl(input int u, input int sel, input logic v);
        @(posedge clk);
        if (sel == 0) src[u].pin <= v; else src[u].cmp1 <= v;
        repeat (6) @(posedge clk);
    endtask : lvl

    task automatic wait_flag(input int u);
        for (int i = 0; i < 80 && flg[u] !== 1'b1; i++) @(posedge clk);
        #1;
    endtask : wait_flag

    task automatic t_reset;
        rd(OFS_CTRL0, 8'h00, "ctrl0"); rd(OFS_HOLDH1, 8'h00, "hold1h"); rd(4'hF, 8'h00, "unmapped");
        chk("out", {uo, flg, wake}, 5'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_capture;
        tmr(16'hA5C3, 1'b0);
        wr(OFS_CTRL0, {4'h8, MODE_CAP_RISE});
        wr(OFS_FLAGS, 8'h03);
        lvl(0, 0, 1'b1);
        rd(OFS_HOLDL0, 8'hC3, "hold0l");
        rd(OFS_HOLDH0, 8'hA5, "hold0h");
        lvl(0, 0, 1'b0); tmr(16'h1234, 1'b0); lvl(0, 0, 1'b1);
        rd(OFS_HOLDL0, 8'h34, "overwrite");
        repeat (20) @(posedge clk);
        chk("flag sticky", flg, 2'b01);
        wr(OFS_FLAGS, 8'h01); #1 chk("flag clr", flg, 2'b00);
        // Unit one falls on comparator one, pin ignored
        wr(OFS_SRC1, 8'h01); src[1].cmp1 <= 1'b1;
        wr(OFS_CTRL1, {4'h8, MODE_CAP_FALL}); wr(OFS_FLAGS, 8'h03);
        lvl(1, 0, 1'b1); lvl(1, 0, 1'b0); chk("src sel", flg, 2'b00);
        lvl(1, 1, 1'b0); chk("fall cap", flg, 2'b10);
        rd(OFS_HOLDH1, 8'h12, "hold1h");
        $display("test capture done");
    endtask : t_capture

    task automatic t_prescale;
        // flag cleared after each switch to MODE_CAP_R4
        src[0].pin <= 1'b0;
        wr(OFS_CTRL0, {4'h8, MODE_CAP_R4}); wr(OFS_FLAGS, 8'h03);
        repeat (2) begin lvl(0, 0, 1'b1); lvl(0, 0, 1'b0); end
        wr(OFS_CTRL0, 8'h00); wr(OFS_CTRL0, {4'h8, MODE_CAP_R4}); wr(OFS_FLAGS, 8'h03);
        repeat (3) begin lvl(0, 0, 1'b1); lvl(0, 0, 1'b0); end
        chk("pre cleared", flg, 2'b00);
        lvl(0, 0, 1'b1); chk("fourth", flg, 2'b01);
        $display("test prescale done");
    endtask : t_prescale

    // Compare one mode, expect output level
    task automatic cmp(input tccu_mode_t m, input logic e, input string nm);
        wr(OFS_CTRL0, {4'h8, m}); wr(OFS_FLAGS, 8'h03);
        tmr(16'h01F8, 1'b1); wait_flag(0);
        chk(nm, {flg[0], uo[0], uoi[0]}, {1'b1, e, e});
        run <= 1'b0;
    endtask : cmp

    task automatic t_compare;
        wr(OFS_CTRL0, 8'h00); wr(OFS_HOLDL0, 8'h00); wr(OFS_HOLDH0, 8'h02);
        cmp(MODE_CMP_TGL, 1'b1, "toggle"); cmp(MODE_CMP_CLR, 1'b0, "clear");
        cmp(MODE_CMP_SET, 1'b1, "set"); cmp(MODE_CMP_SWI, 1'b1, "swint");
        wr(OFS_CTRL0, 8'h00); #1 chk("latch low", uo[0], 1'b0);
        tsel <= 2'b01; tmr(16'h0200, 1'b0);
        wr(OFS_CTRL0, {4'h8, MODE_CMP_TRIG});
        // Trigger stands one cycle: look just after each edge, never at it
        for (int i = 0; i < 10 && ctrg[0] !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
        end
        chk("trig+reset", {ctrg[0], trst[0], uo[0]}, 3'b110);
        tsel <= 2'b00;
        $display("test compare done");
    endtask : t_compare

    task automatic t_sleep;
        src[0].pin <= 1'b0;
        wr(OFS_CTRL0, {4'h8, MODE_CAP_RISE}); wr(OFS_FLAGS, 8'h03);
        slp <= 1'b1; lvl(0, 0, 1'b1); chk("sleep int", flg, 2'b00);
        ext <= 1'b1; lvl(0, 0, 1'b0); lvl(0, 0, 1'b1); chk("sleep ext", flg, 2'b01);
        #1 chk("no wake", wake, 1'b0);
        wr(OFS_ENAB, 8'h01); #1 chk("wake", wake, 1'b1);
        rd(OFS_ENAB, 8'h01, "enab");
        wr(OFS_FLAGS, 8'h01); #1 chk("wake off", wake, 1'b0);
        slp <= 1'b0; ext <= 1'b0;
        $display("test sleep done");
    endtask : t_sleep

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up

    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        t_reset(); t_capture(); t_prescale(); t_compare(); t_sleep();
        wrap_up();
    end

    // Watchdog
    initial
    begin
        #1000000;
        error_cnt++;
        wrap_up();
    end
endmodule : tccu_top_test
`default_nettype wire
